// >>> core/low_power_measurement_sequencer.sv
// Contract
// - On entering light or deep light sleep, power down all ADC analog blocks.
// - With no measurements, wake only on watchdog, sleep timer or LIN wakeup.
// - Enable bits: 0 watchdog, 1 sleep timer, 4 LIN wakeup.
// - No enabled wake source means staying asleep until power-on reset.
// - State select 0 or 1 is light sleep, 2 is deep light sleep.
// - Setup 0 none, 1 discrete current, 2 current plus voltage plus internal temp.
// - Setup field sits in config bits 4:2 and picks temperature source.
// - Without chip select rising after the command, stay in full power.
// - Any enabled wake restores full-power configuration settings.
// - After stabilising, re-enable MCU clock; release MCU reset leaving deep sleep.
// - Discrete current mode keeps the voltage/temperature ADC off throughout.
// - Current ADC off at entry and between windows; powered on trigger only.
// - Several consecutive current conversions per triggered window are configurable.
// - Discrete current mode also wakes on enabled current ADC interrupts.
// - Enabled interrupt during a measurement aborts it and returns to full power.
// - Trigger timer compare value sets the interval between windows.
// - Three-parameter mode powers both ADCs down at entry and between windows.
// - After configured voltage conversions, reconfigure and take one temperature conversion.
// - With loop count N, measure current only N periods, then voltage and temp.
// - Loop count 0 measures voltage and temperature every period.
// - Three-parameter mode wakes on all interrupts except LIN short and TXD timeout.
// - Setup 3 measures external instead of internal temperature.
// - Entry clears sleep and trigger timers; trigger runs only in discrete setups.
module low_power_measurement_sequencer import lpm_seq_pkg::*; #(
	parameter int TIMER_W = 16,
	parameter int CONV_W = 4,
	parameter int CURR_IRQ_MASK = 16'h0f00,
	parameter int NOWAKE_MASK = 16'h0060
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Command port from the SPI slave
	input wire logic cmd_wr,
	input wire logic [7:0] sleep_command_reg,
	input wire logic csn,
	// Configuration
	input wire logic [7:0] sleep_power_config,
	input wire logic [7:0] full_power_config,
	input wire logic [IRQ_W-1:0] interrupt_enable_bits,
	input wire logic [TIMER_W-1:0] sleep_timer_compare,
	input wire logic [TIMER_W-1:0] adc_trigger_compare,
	input wire logic [7:0] current_only_loop_count,
	input wire logic [CONV_W-1:0] curr_conv_count,
	input wire logic [CONV_W-1:0] volt_conv_count,
	// Events
	input wire logic [IRQ_W-1:0] irq_pending,
	input wire logic conv_done_i,
	input wire logic conv_done_v,
	// Power control outputs
	output logic asleep,
	output logic pwr_adc_i,
	output logic pwr_adc_v,
	output logic adc_v_temp_sel,
	output logic adc_v_ext_temp,
	output logic [7:0] active_power_config,
	output logic mcu_clk_en,
	output logic mcu_rst_n,
	output logic regs_sleep_n,
	output logic sleep_timer_valid,
	output logic [TIMER_W-1:0] sleep_timer_value,
	output logic wake_pulse
);
	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	function automatic logic [2:0] meas_of(input logic [7:0] cfg);
		meas_of = cfg[MEAS_MSB:MEAS_LSB];
	endfunction
	function automatic logic is_deep(input logic [7:0] cfg);
		is_deep = (cfg[ST_SEL_W-1:0] == ST_DEEP);
	endfunction

	seq_state_t state_reg, state_next;
	logic [7:0] lp_cfg_reg;
	logic armed_cmd;
	logic [TIMER_W-1:0] sleep_t_reg;
	logic [TIMER_W-1:0] trig_t_reg;
	logic [7:0] loop_reg;
	logic [CONV_W-1:0] conv_reg;
	logic [$clog2(STABLE_CYC+1):0] stab_reg;
	logic [IRQ_W-1:0] wake_mask;
	logic [2:0] meas;
	logic discrete;
	logic sleeping;
	logic sleep_t_hit;
	logic trig_fire;
	logic wake;
	logic entering;
	logic full_next;
	logic [7:0] cfg_now;

	assign meas = meas_of(lp_cfg_reg);
	assign discrete = (meas == MEAS_DISC_I) || (meas == MEAS_DISC_IVT) || (meas == MEAS_DISC_IVX);
	assign sleeping = (state_reg == S_SLEEP_IDLE) || (state_reg == S_MEAS_I)
		|| (state_reg == S_MEAS_V) || (state_reg == S_MEAS_T);
	assign sleep_t_hit = (sleep_t_reg == sleep_timer_compare);
	assign trig_fire = discrete && (trig_t_reg == adc_trigger_compare);
	assign armed_cmd = cmd_wr && (sleep_command_reg == SLEEP_CMD_CODE);
	assign entering = (state_reg == S_ARMED) && (state_next == S_SLEEP_IDLE);
	assign full_next = (state_next == S_FULL) || (state_next == S_ARMED);
	// The entry edge must drive the new setup, not the one latched for the last sleep
	assign cfg_now = entering ? sleep_power_config : lp_cfg_reg;

	// ----------------------------------------
	// Wake source selection
	// ----------------------------------------
	always_comb begin
		wake_mask = '0;
		wake_mask[IRQ_WDOG] = 1'b1;
		wake_mask[IRQ_SLEEPT] = 1'b1;
		wake_mask[IRQ_LINWU] = 1'b1;
		case (meas)
			MEAS_DISC_I: wake_mask = wake_mask | IRQ_W'(CURR_IRQ_MASK);
			MEAS_DISC_IVT, MEAS_DISC_IVX: wake_mask = ~IRQ_W'(NOWAKE_MASK);
			default: wake_mask = wake_mask;
		endcase
	end

	// Nothing enabled means wake never fires; only reset leaves sleep
	assign wake = sleeping && |(irq_pending & interrupt_enable_bits & wake_mask);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_FULL: begin
				if (armed_cmd) begin
					state_next = S_ARMED;
				end
			end
			S_ARMED: begin
				if (cmd_wr && !armed_cmd) begin
					state_next = S_FULL;
				end else if (csn) begin
					state_next = S_SLEEP_IDLE;
				end
			end
			S_SLEEP_IDLE: begin
				if (wake) begin
					state_next = S_WAKE;
				end else if (trig_fire) begin
					state_next = S_MEAS_I;
				end
			end
			S_MEAS_I: begin
				if (wake) begin
					state_next = S_WAKE;
				end else if (conv_done_i && conv_reg >= curr_conv_count) begin
					if (meas != MEAS_DISC_I && loop_reg >= current_only_loop_count) begin
						state_next = S_MEAS_V;
					end else begin
						state_next = S_SLEEP_IDLE;
					end
				end
			end
			S_MEAS_V: begin
				if (wake) begin
					state_next = S_WAKE;
				end else if (conv_done_v && conv_reg >= volt_conv_count) begin
					state_next = S_MEAS_T;
				end
			end
			S_MEAS_T: begin
				if (wake) begin
					state_next = S_WAKE;
				end else if (conv_done_v) begin
					state_next = S_SLEEP_IDLE;
				end
			end
			S_WAKE: begin
				if (stab_reg >= STABLE_CYC[$bits(stab_reg)-1:0]) begin
					state_next = S_FULL;
				end
			end
			default: state_next = S_FULL;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= S_FULL;
		end else begin
			state_reg <= state_next;
		end
	end

	// Configuration latched at sleep entry (chip select release) so mid-sleep writes cannot upset the setup
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lp_cfg_reg <= 8'h00;
		end else if (entering) begin
			lp_cfg_reg <= sleep_power_config;
		end
	end

	// ----------------------------------------
	// Timers
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sleep_t_reg <= '0;
			sleep_timer_valid <= 1'b0;
		end else if (entering) begin
			sleep_t_reg <= '0;
			sleep_timer_valid <= 1'b1;
		end else if (sleeping && !sleep_t_hit) begin
			sleep_t_reg <= sleep_t_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trig_t_reg <= '0;
		end else if (entering || trig_fire || !sleeping) begin
			trig_t_reg <= '0;
		end else if (discrete) begin
			trig_t_reg <= trig_t_reg + 1'b1;
		end
	end

	// Current-only loop counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			loop_reg <= LOOP_CNT_RST;
		end else if (entering || state_next == S_MEAS_T) begin
			loop_reg <= LOOP_CNT_RST;
		end else if (state_reg == S_MEAS_I && state_next == S_SLEEP_IDLE && loop_reg != 8'hff) begin
			loop_reg <= loop_reg + 8'h01;
		end
	end

	// Conversions in the current phase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_reg <= '0;
		end else if (state_next != state_reg) begin
			conv_reg <= CONV_W'(1);
		end else if ((state_reg == S_MEAS_I && conv_done_i)
			|| (state_reg == S_MEAS_V && conv_done_v)) begin
			conv_reg <= conv_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stab_reg <= '0;
		end else if (state_reg == S_WAKE) begin
			stab_reg <= stab_reg + 1'b1;
		end else begin
			stab_reg <= '0;
		end
	end

	// ----------------------------------------
	// Sleep status and microcontroller clock
	// ----------------------------------------
	// The armed state still counts as full power
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			asleep <= 1'b0;
			mcu_clk_en <= 1'b1;
		end else begin
			asleep <= !full_next;
			// Clock returns only once the wake stabilisation count has run out
			mcu_clk_en <= full_next;
		end
	end

	// ----------------------------------------
	// ADC power gating
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pwr_adc_i <= 1'b0;
			pwr_adc_v <= 1'b0;
		end else if (full_next) begin
			pwr_adc_i <= full_power_config[0];
			pwr_adc_v <= full_power_config[1];
		end else begin
			// Off at entry, between windows and while waking
			pwr_adc_i <= (state_next == S_MEAS_I) || (state_next == S_MEAS_V)
				|| (state_next == S_MEAS_T);
			// Current-only windows never leave the current phase
			pwr_adc_v <= (state_next == S_MEAS_V) || (state_next == S_MEAS_T);
		end
	end

	// ----------------------------------------
	// Voltage and temperature converter setup
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			adc_v_temp_sel <= 1'b0;
			adc_v_ext_temp <= 1'b0;
		end else begin
			adc_v_temp_sel <= (state_next == S_MEAS_T);
			adc_v_ext_temp <= (meas_of(cfg_now) == MEAS_DISC_IVX);
		end
	end

	// ----------------------------------------
	// Analog configuration in force
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			active_power_config <= FULL_CFG_RST;
		end else begin
			// Full-power settings come back whatever was powered while asleep
			active_power_config <= full_next ? full_power_config : cfg_now;
		end
	end

	// ----------------------------------------
	// Microcontroller reset and supply
	// ----------------------------------------
	// Deep light sleep drops the microcontroller supply; its reset holds until full power
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mcu_rst_n <= 1'b1;
			regs_sleep_n <= 1'b1;
		end else if (state_next == S_SLEEP_IDLE && is_deep(cfg_now)) begin
			mcu_rst_n <= 1'b0;
			regs_sleep_n <= 1'b0;
		end else if (state_next == S_FULL) begin
			// Released together with the clock, after stabilisation
			mcu_rst_n <= 1'b1;
			regs_sleep_n <= 1'b1;
		end
	end

	// One-cycle marker on the return to full power
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wake_pulse <= 1'b0;
		end else begin
			wake_pulse <= (state_reg == S_WAKE) && (state_next == S_FULL);
		end
	end

	assign sleep_timer_value = sleep_t_reg;
endmodule

// >>> core/lpm_seq_pkg.sv
package lpm_seq_pkg;
	// ----------------------------------------
	// Command and field encodings
	// ----------------------------------------
	localparam logic [7:0] SLEEP_CMD_CODE = 8'ha9;
	localparam int ST_SEL_W = 2;
	localparam logic [1:0] ST_DEEP = 2'h2;
	localparam int MEAS_LSB = 2;
	localparam int MEAS_MSB = 4;
	localparam logic [2:0] MEAS_NONE = 3'h0;
	localparam logic [2:0] MEAS_DISC_I = 3'h1;
	localparam logic [2:0] MEAS_DISC_IVT = 3'h2;
	localparam logic [2:0] MEAS_DISC_IVX = 3'h3;
	// ----------------------------------------
	// Interrupt enable bit positions
	// ----------------------------------------
	localparam int IRQ_WDOG = 0;
	localparam int IRQ_SLEEPT = 1;
	localparam int IRQ_LINWU = 4;
	localparam int IRQ_W = 16;
	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [7:0] FULL_CFG_RST = 8'h00;
	localparam logic [7:0] LOOP_CNT_RST = 8'h00;
	localparam int CLK_HZ = 25000000;
	localparam int STABLE_NS = 1000;
	localparam int STABLE_CYC = (STABLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	typedef enum logic [2:0] {
		S_FULL,
		S_ARMED,
		S_SLEEP_IDLE,
		S_MEAS_I,
		S_MEAS_V,
		S_MEAS_T,
		S_WAKE
	} seq_state_t;
endpackage

// >>> verification/adc_partner_model.sv
module adc_partner_model #(
	parameter int CONV_CYC = 3
) (
	input wire logic clk,
	input wire logic pwr_adc_i,
	input wire logic pwr_adc_v,
	output logic conv_done_i = 1'b0,
	output logic conv_done_v = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	int ci = 0;
	int cv = 0;
	// A powered converter finishes one conversion every CONV_CYC cycles
	always @(posedge clk) begin
		ci <= pwr_adc_i ? (ci + 1) % CONV_CYC : 0;
		cv <= pwr_adc_v ? (cv + 1) % CONV_CYC : 0;
		conv_done_i <= pwr_adc_i && ci == CONV_CYC - 1;
		conv_done_v <= pwr_adc_v && cv == CONV_CYC - 1;
	end
endmodule

// >>> verification/low_power_measurement_sequencer_tb_top.sv
bind low_power_measurement_sequencer lpm_seq_asserts lpm_seq_asserts_i (.clk, .arst_n, .csn,
	.sleep_power_config, .full_power_config, .interrupt_enable_bits, .irq_pending, .asleep,
	.pwr_adc_i, .pwr_adc_v, .adc_v_temp_sel, .active_power_config, .mcu_clk_en, .mcu_rst_n,
	.regs_sleep_n, .wake_pulse);
module low_power_measurement_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import lpm_seq_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cmd_wr = 1'b0;
	logic csn = 1'b1;
	logic [7:0] sleep_command_reg = 8'h00;
	logic [7:0] sleep_power_config = 8'h00;
	logic [7:0] full_power_config = 8'h00;
	logic [7:0] current_only_loop_count = 8'h00;
	logic [IRQ_W-1:0] interrupt_enable_bits = '0;
	logic [IRQ_W-1:0] irq_pending = '0;
	logic [15:0] sleep_timer_compare = 16'hffff;
	logic [15:0] adc_trigger_compare = 16'h0010;
	logic [3:0] curr_conv_count = 4'h1;
	logic [3:0] volt_conv_count = 4'h1;
	logic conv_done_i, conv_done_v, asleep, pwr_adc_i, pwr_adc_v, adc_v_temp_sel, adc_v_ext_temp;
	logic mcu_clk_en, mcu_rst_n, regs_sleep_n, sleep_timer_valid, wake_pulse, pi_q, pv_q;
	logic [7:0] active_power_config;
	logic [15:0] sleep_timer_value;
	int error_cnt = 0, tests_run = 0, seed = 57, ni = 0, nv = 0, lc, n;
	int good[3] = '{0, 1, 4};
	bit saw_ext = 0;
	always #20 clk = ~clk;
	low_power_measurement_sequencer low_power_measurement_sequencer_i (.clk, .arst_n, .cmd_wr,
		.sleep_command_reg, .csn, .sleep_power_config, .full_power_config, .interrupt_enable_bits,
		.sleep_timer_compare, .adc_trigger_compare, .current_only_loop_count, .curr_conv_count,
		.volt_conv_count, .irq_pending, .conv_done_i, .conv_done_v, .asleep, .pwr_adc_i,
		.pwr_adc_v, .adc_v_temp_sel, .adc_v_ext_temp, .active_power_config, .mcu_clk_en,
		.mcu_rst_n, .regs_sleep_n, .sleep_timer_valid, .sleep_timer_value, .wake_pulse);
	adc_partner_model adc_partner_model_i (.clk, .pwr_adc_i, .pwr_adc_v, .conv_done_i,
		.conv_done_v);
	// Count measurement windows opened while asleep
	always @(posedge clk) begin
		pi_q <= pwr_adc_i;
		pv_q <= pwr_adc_v;
		if (asleep && pwr_adc_i && !pi_q) ni++;
		if (asleep && pwr_adc_v && !pv_q) nv++;
		if (asleep && adc_v_ext_temp && adc_v_temp_sel) saw_ext = 1;
	end
	function automatic int rnd(input int k);
		return $unsigned($random(seed)) % k;
	endfunction
	function automatic logic [15:0] rst_view();
		return {mcu_clk_en, mcu_rst_n, regs_sleep_n, asleep, sleep_timer_valid, pwr_adc_i,
			pwr_adc_v, wake_pulse, active_power_config};
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic go_sleep(input logic [7:0] cfg, input logic [15:0] en, input logic [7:0] code,
		input bit rel);
		@(posedge clk);
		sleep_power_config <= cfg;
		interrupt_enable_bits <= en;
		csn <= 1'b0;
		ni = 0;
		nv = 0;
		saw_ext = 0;
		@(posedge clk);
		cmd_wr <= 1'b1;
		sleep_command_reg <= code;
		@(posedge clk);
		cmd_wr <= 1'b0;
		csn <= rel;
		repeat (3) @(posedge clk);
		#1;
		chk("asleep", code == SLEEP_CMD_CODE && rel, asleep);
		if (asleep) begin
			chk("regs_sleep_n", cfg[1:0] != ST_DEEP, regs_sleep_n);
			chk("sleep_cfg", cfg, active_power_config);
			chk("sleep_timer", 16'h0002, sleep_timer_value);
			chk("timer_valid", 1, sleep_timer_valid);
		end
	endtask
	task automatic wake(input int b);
		@(posedge clk);
		irq_pending[b] <= 1'b1;
		n = 0;
		while (asleep && n < 60) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("woken", 0, asleep);
		chk("active_cfg", full_power_config, active_power_config);
		chk("mcu_clk_rst", 2'b11, {mcu_clk_en, mcu_rst_n});
		chk("wake_pulse", 1, wake_pulse);
		@(posedge clk);
		irq_pending <= '0;
	endtask
	initial begin
		repeat (7) @(posedge clk);
		#1;
		chk("reset_outs", {8'he0, FULL_CFG_RST}, rst_view());
		@(posedge clk);
		arst_n <= 1'b1;
		go_sleep(8'h00, 16'h0002, SLEEP_CMD_CODE, 1'b0);
		go_sleep(8'h00, 16'h0002, 8'h00, 1'b1);
		for (int s = 0; s < 3; s++) begin
			for (int m = 0; m < 4; m++) begin
				@(posedge clk);
				adc_trigger_compare <= 16'(8 + rnd(16));
				curr_conv_count <= 4'(1 + rnd(3));
				volt_conv_count <= 4'(1 + rnd(3));
				lc = (s == 0) ? 0 : rnd(4);
				current_only_loop_count <= 8'(lc);
				full_power_config <= 8'(rnd(256));
				go_sleep({3'(rnd(8)), 3'(m), 2'(s)}, 16'h0f60 | (16'h1 << good[s]), 8'ha9, 1'b1);
				n = 0;
				while ((ni < 4 || pwr_adc_i || pwr_adc_v) && n < 400) begin
					@(posedge clk);
					#1;
					n++;
				end
				chk("cur_windows", m > 0, ni >= 4);
				chk("volt_windows", (m < 2) ? 0 : ni / (lc + 1), 16'(nv));
				chk("ext_temp", m == 3, saw_ext);
				@(posedge clk);
				irq_pending[(m == 0) ? 8 : 5] <= 1'b1;
				repeat (40) @(posedge clk);
				#1;
				chk("held_asleep", 1, asleep);
				wake((m == 0) ? good[s] : 8);
			end
		end
		go_sleep(8'h00, 16'h0000, SLEEP_CMD_CODE, 1'b1);
		@(posedge clk);
		irq_pending <= 16'h0013;
		repeat (60) @(posedge clk);
		#1;
		chk("no_source", 1, asleep);
		@(posedge clk);
		arst_n <= 1'b0;
		irq_pending <= '0;
		repeat (8) @(posedge clk);
		#1;
		chk("reset_wakes", {8'he0, FULL_CFG_RST}, rst_view());
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report();
	end
endmodule

// >>> verification/lpm_seq_asserts.sv
module lpm_seq_asserts import lpm_seq_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic csn,
	input wire logic [7:0] sleep_power_config,
	input wire logic [7:0] full_power_config,
	input wire logic [IRQ_W-1:0] interrupt_enable_bits,
	input wire logic [IRQ_W-1:0] irq_pending,
	input wire logic asleep,
	input wire logic pwr_adc_i,
	input wire logic pwr_adc_v,
	input wire logic adc_v_temp_sel,
	input wire logic [7:0] active_power_config,
	input wire logic mcu_clk_en,
	input wire logic mcu_rst_n,
	input wire logic regs_sleep_n,
	input wire logic wake_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [5:0] quiet_reg;
	logic fixed_src;
	assign fixed_src = |(irq_pending & interrupt_enable_bits & 16'h0013);
	// Cycles asleep with no enabled source pending
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			quiet_reg <= 6'h00;
		else if (!asleep || |(irq_pending & interrupt_enable_bits))
			quiet_reg <= 6'h00;
		else if (quiet_reg != 6'h3f)
			quiet_reg <= quiet_reg + 6'h01;
	end
	sequence entry_s;
		!asleep ##1 asleep;
	endsequence
	AST_ENTRY_CSN: assert property (entry_s |-> $past(csn) && !mcu_clk_en)
		else $error("sleep entered without chip select release");
	AST_ENTRY_ADC_OFF: assert property (entry_s |-> !pwr_adc_i && !pwr_adc_v)
		else $error("ADC powered at sleep entry");
	AST_DEEP_SEL: assert property (entry_s |-> (regs_sleep_n ==
		(sleep_power_config[ST_SEL_W-1:0] != ST_DEEP)) && (mcu_rst_n == regs_sleep_n))
		else $error("sleep state select not honoured");
	AST_RST_HELD: assert property (!mcu_rst_n |-> asleep && !mcu_clk_en)
		else $error("mcu reset low outside sleep");
	AST_RESTORE: assert property ($fell(asleep) |-> wake_pulse && mcu_clk_en && mcu_rst_n
		&& active_power_config == full_power_config)
		else $error("full power settings not restored on wake");
	AST_NO_WAKE: assert property ($fell(asleep) |-> $past(quiet_reg) < 6'h1e)
		else $error("woke without an enabled source");
	AST_WAKE_BOUND: assert property (asleep && fixed_src |-> ##[1:40] !asleep)
		else $error("enabled wake source ignored");
	AST_TEMP_V: assert property (adc_v_temp_sel |-> pwr_adc_v && asleep)
		else $error("temperature select without V ADC power");
	AST_V_GATE: assert property (pwr_adc_v && asleep |->
		sleep_power_config[MEAS_MSB:MEAS_LSB] >= MEAS_DISC_IVT)
		else $error("V ADC powered in a current-only setup");
endmodule
